// File: inc/ldst_pkg.sv
// Shared constants and types for the load and store execution unit.
package ldst_pkg;
   // ---------------------------------------------------------------
   // Register numbers and address arithmetic
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LR = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;
   localparam int NUM_REGS = 16;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [31:0] PC_PIPE_OFFSET = 32'h0000_0004;
   localparam logic [31:0] WORD_ALIGN_MASK = 32'hffff_fffc;
   localparam logic [31:0] HALF_ALIGN_MASK = 32'hffff_fffe;
   localparam logic signed [31:0] SINGLE_OFFSET_MAX = 32'sd4095;
   localparam logic signed [31:0] DUAL_OFFSET_MAX = 32'sd1020;
   localparam int BYTE_MSB = 7;
   localparam int HALF_MSB = 15;
   // ---------------------------------------------------------------
   // Operations, sizes, addressing modes and states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_LOAD_REGISTER = 2'h0,
      OP_LOAD_DUAL_WORDS = 2'h1,
      OP_LOAD_MULTIPLE = 2'h2,
      OP_STORE_MULTIPLE = 2'h3
   } op_t;
   typedef enum logic [2:0] {
      SIZE_WORD = 3'h0,
      SIZE_BYTE_U = 3'h1,
      SIZE_BYTE_S = 3'h2,
      SIZE_HALF_U = 3'h3,
      SIZE_HALF_S = 3'h4
   } size_t;
   typedef enum logic [2:0] {
      MODE_DEFAULT = 3'h0,
      MODE_INCREMENT_AFTER = 3'h1,
      MODE_DECREMENT_BEFORE = 3'h2,
      MODE_FULL_DESCENDING_POP = 3'h3,
      MODE_EMPTY_ASCENDING_POP = 3'h4,
      MODE_EMPTY_ASCENDING_PUSH = 3'h5,
      MODE_FULL_DESCENDING_PUSH = 3'h6
   } mode_t;
   localparam logic [1:0] MEM_BYTE = 2'h0;
   localparam logic [1:0] MEM_HALF = 2'h1;
   localparam logic [1:0] MEM_WORD = 2'h2;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PICK = 5'h02,
      ST_READ = 5'h04,
      ST_ACCESS = 5'h08,
      ST_DONE = 5'h10
   } state_t;
endpackage

// File: inc/pick_if.sv
// Carrier between the sequencer and the register list picker.
`timescale 1ns/1ps
interface pick_if;
   logic [15:0] mask;
   logic from_top;
   logic [3:0] idx;
   logic any;
   modport user (output mask, output from_top, input idx, input any);
   modport picker (input mask, input from_top, output idx, output any);
endinterface

// File: core/reglist_pick.sv
// Picks the lowest or highest remaining register of a transfer list.
`timescale 1ns/1ps
module reglist_pick (
   pick_if.picker pk
);
   // ---------------------------------------------------------------
   // Priority chains, one stage per register
   // ---------------------------------------------------------------
   logic [3:0] lo [0:16];
   logic [3:0] hi [0:16];
   assign lo[16] = 4'h0;
   assign hi[0] = 4'h0;
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_chain
         assign lo[i] = pk.mask[i] ? 4'(i) : lo[i + 1];
         assign hi[i + 1] = pk.mask[i] ? 4'(i) : hi[i];
      end
   endgenerate
   assign pk.idx = pk.from_top ? hi[16] : lo[0];
   assign pk.any = |pk.mask;
endmodule

// File: core/ldst_exec.sv
// Execution unit for PC-relative loads and load/store multiple.
`timescale 1ns/1ps
module ldst_exec (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire ldst_pkg::op_t cmd_op,
   input wire ldst_pkg::size_t cmd_size,
   input wire ldst_pkg::mode_t cmd_mode,
   input wire logic cmd_writeback,
   input wire logic cmd_by_label,
   input wire logic [31:0] cmd_operand,
   input wire logic [31:0] cmd_pc,
   input wire logic [3:0] cmd_target_reg,
   input wire logic [3:0] cmd_second_target_reg,
   input wire logic [3:0] cmd_base_reg,
   input wire logic [31:0] cmd_base_val,
   input wire logic [15:0] cmd_reg_list,
   output logic cmd_error,
   output logic done,
   output logic [3:0] rf_rd_addr,
   input wire logic [31:0] rf_rd_data,
   output logic rf_wr_en,
   output logic [3:0] rf_wr_addr,
   output logic [31:0] rf_wr_data,
   output logic flags_wr_en,
   output logic branch_valid,
   output logic [31:0] branch_addr,
   output logic branch_fault,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [1:0] mem_size,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   // ---------------------------------------------------------------
   // State and held command
   // ---------------------------------------------------------------
   ldst_pkg::state_t st;
   ldst_pkg::state_t next_st;
   ldst_pkg::op_t op_q;
   ldst_pkg::size_t size_q;
   logic decr_q;
   logic wb_q;
   logic dual_second_q;
   logic [3:0] base_reg_q;
   logic [3:0] target_q;
   logic [3:0] second_q;
   logic [15:0] mask_q;
   logic [31:0] addr_q;
   logic [31:0] start_q;
   pick_if pk ();
   reglist_pick u_pick (.pk(pk));

   // ---------------------------------------------------------------
   // Decode and address selection
   // ---------------------------------------------------------------
   wire take = cmd_valid && cmd_ready;
   wire take_multi = cmd_op == ldst_pkg::OP_LOAD_MULTIPLE || cmd_op == ldst_pkg::OP_STORE_MULTIPLE;
   wire take_dual = cmd_op == ldst_pkg::OP_LOAD_DUAL_WORDS;
   wire ldst_pkg::size_t take_size = cmd_op == ldst_pkg::OP_LOAD_REGISTER ? cmd_size
      : ldst_pkg::SIZE_WORD;
   wire decr_sel = cmd_mode == ldst_pkg::MODE_DECREMENT_BEFORE
      || cmd_mode == ldst_pkg::MODE_EMPTY_ASCENDING_POP
      || cmd_mode == ldst_pkg::MODE_FULL_DESCENDING_PUSH;
   wire [31:0] pc_base = (cmd_pc & ldst_pkg::WORD_ALIGN_MASK)
      + ldst_pkg::PC_PIPE_OFFSET;
   wire [31:0] pcrel_addr = cmd_by_label ? cmd_operand : pc_base + cmd_operand;
   wire signed [31:0] pcrel_off = $signed(pcrel_addr - pc_base);
   wire signed [31:0] off_lim = take_dual ? ldst_pkg::DUAL_OFFSET_MAX
      : ldst_pkg::SINGLE_OFFSET_MAX;
   wire range_ok = take_multi
      || (pcrel_off <= off_lim && pcrel_off >= -off_lim);
   wire [31:0] first_addr = take_multi ? cmd_base_val : pcrel_addr;
   wire is_multi = op_q == ldst_pkg::OP_LOAD_MULTIPLE || op_q == ldst_pkg::OP_STORE_MULTIPLE;
   wire is_store = op_q == ldst_pkg::OP_STORE_MULTIPLE;
   wire [31:0] next_addr = decr_q ? addr_q - ldst_pkg::WORD_BYTES
      : addr_q + ldst_pkg::WORD_BYTES;
   wire [3:0] single_idx = dual_second_q ? second_q : target_q;
   wire [3:0] pick_idx = is_multi ? pk.idx : single_idx;
   wire more = is_multi ? (mask_q != 16'h0000)
      : (op_q == ldst_pkg::OP_LOAD_DUAL_WORDS && !dual_second_q);
   wire [1:0] access_size = (is_multi || size_q == ldst_pkg::SIZE_WORD) ? ldst_pkg::MEM_WORD
      : (size_q == ldst_pkg::SIZE_BYTE_U || size_q == ldst_pkg::SIZE_BYTE_S) ? ldst_pkg::MEM_BYTE
      : ldst_pkg::MEM_HALF;
   assign pk.mask = mask_q;
   assign pk.from_top = decr_q;

   // ---------------------------------------------------------------
   // Load data extension
   // ---------------------------------------------------------------
   wire [31:0] byte_z = {24'h00_0000, mem_rdata[ldst_pkg::BYTE_MSB:0]};
   wire [31:0] byte_s = {{24{mem_rdata[ldst_pkg::BYTE_MSB]}}, mem_rdata[ldst_pkg::BYTE_MSB:0]};
   wire [31:0] half_z = {16'h0000, mem_rdata[ldst_pkg::HALF_MSB:0]};
   wire [31:0] half_s = {{16{mem_rdata[ldst_pkg::HALF_MSB]}}, mem_rdata[ldst_pkg::HALF_MSB:0]};
   wire [31:0] load_ext = is_multi ? mem_rdata
      : size_q == ldst_pkg::SIZE_BYTE_U ? byte_z
      : size_q == ldst_pkg::SIZE_BYTE_S ? byte_s
      : size_q == ldst_pkg::SIZE_HALF_U ? half_z
      : size_q == ldst_pkg::SIZE_HALF_S ? half_s : mem_rdata;
   wire load_to_pc = rf_rd_addr == ldst_pkg::REG_PC;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      unique case (st)
         ldst_pkg::ST_IDLE: if (take && range_ok) next_st = ldst_pkg::ST_PICK;
         ldst_pkg::ST_PICK: next_st = ldst_pkg::ST_READ;
         ldst_pkg::ST_READ: next_st = ldst_pkg::ST_ACCESS;
         ldst_pkg::ST_ACCESS: if (mem_ack) next_st = more ? ldst_pkg::ST_PICK : ldst_pkg::ST_DONE;
         ldst_pkg::ST_DONE: next_st = ldst_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= ldst_pkg::ST_IDLE;
         cmd_ready <= 1'b0;
      end else begin
         st <= next_st;
         cmd_ready <= next_st == ldst_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         op_q <= ldst_pkg::OP_LOAD_REGISTER;
         size_q <= ldst_pkg::SIZE_WORD;
         decr_q <= 1'b0;
         wb_q <= 1'b0;
         base_reg_q <= 4'h0;
         target_q <= 4'h0;
         second_q <= 4'h0;
         start_q <= 32'h0000_0000;
      end else if (take && range_ok) begin
         op_q <= cmd_op;
         size_q <= take_size;
         decr_q <= take_multi && decr_sel;
         wb_q <= take_multi && cmd_writeback;
         base_reg_q <= cmd_base_reg;
         target_q <= cmd_target_reg;
         second_q <= cmd_second_target_reg;
         start_q <= first_addr;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mask_q <= 16'h0000;
         addr_q <= 32'h0000_0000;
         dual_second_q <= 1'b0;
         rf_rd_addr <= 4'h0;
      end else if (take && range_ok) begin
         mask_q <= cmd_reg_list;
         addr_q <= first_addr;
         dual_second_q <= 1'b0;
      end else if (st == ldst_pkg::ST_PICK) begin
         rf_rd_addr <= pick_idx;
         if (is_multi) mask_q[pk.idx] <= 1'b0;
      end else if (st == ldst_pkg::ST_ACCESS && mem_ack && more) begin
         addr_q <= next_addr;
         dual_second_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Memory side
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_size <= ldst_pkg::MEM_WORD;
         mem_wdata <= 32'h0000_0000;
      end else if (st == ldst_pkg::ST_READ) begin
         mem_req <= 1'b1;
         mem_we <= is_store;
         mem_addr <= addr_q;
         mem_size <= access_size;
         mem_wdata <= rf_rd_data;
      end else if (st == ldst_pkg::ST_ACCESS && mem_ack) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register file, branch and status side
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rf_wr_en <= 1'b0;
         rf_wr_addr <= 4'h0;
         rf_wr_data <= 32'h0000_0000;
         branch_valid <= 1'b0;
         branch_addr <= 32'h0000_0000;
         branch_fault <= 1'b0;
         flags_wr_en <= 1'b0;
         cmd_error <= 1'b0;
         done <= 1'b0;
      end else begin
         rf_wr_en <= 1'b0;
         branch_valid <= 1'b0;
         flags_wr_en <= 1'b0;
         cmd_error <= take && !range_ok;
         done <= st == ldst_pkg::ST_DONE;
         if (st == ldst_pkg::ST_ACCESS && mem_ack && !is_store) begin
            if (load_to_pc) begin
               branch_valid <= 1'b1;
               branch_addr <= mem_rdata & ldst_pkg::HALF_ALIGN_MASK;
               branch_fault <= !mem_rdata[0];
            end else begin
               rf_wr_en <= 1'b1;
               rf_wr_addr <= rf_rd_addr;
               rf_wr_data <= load_ext;
            end
         end else if (st == ldst_pkg::ST_DONE && wb_q) begin
            rf_wr_en <= 1'b1;
            rf_wr_addr <= base_reg_q;
            rf_wr_data <= mem_addr;
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [31:0] prev_addr;
   logic seen_access;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || st == ldst_pkg::ST_IDLE) begin
         seen_access <= 1'b0;
         prev_addr <= 32'h0000_0000;
      end else if (st == ldst_pkg::ST_READ) begin
         seen_access <= 1'b1;
         prev_addr <= addr_q;
      end
   end
   sequence s_take_ok;
      take && range_ok;
   endsequence
   sequence s_first_req;
      ##3 (mem_req && mem_addr == $past(first_addr, 3));
   endsequence
   a_flags_unchanged: assert property (!flags_wr_en)
      else $error("flags were written");
   a_pc_branch_target: assert property (branch_valid |-> branch_addr ==
      ($past(mem_rdata) & ldst_pkg::HALF_ALIGN_MASK) && branch_fault == !$past(mem_rdata[0]))
      else $error("branch target not taken from loaded value");
   a_byte_zero_extend: assert property ((rf_wr_en && !is_multi && size_q ==
      ldst_pkg::SIZE_BYTE_U && $past(st) == ldst_pkg::ST_ACCESS) |-> rf_wr_data[31:8] == 24'h0)
      else $error("unsigned byte not zero extended");
   a_half_sign_extend: assert property ((rf_wr_en && !is_multi && size_q ==
      ldst_pkg::SIZE_HALF_S && $past(st) == ldst_pkg::ST_ACCESS)
      |-> rf_wr_data[31:16] == {16{rf_wr_data[15]}})
      else $error("signed halfword not sign extended");
   a_range_refused: assert property ((take && !range_ok) |=>
      (cmd_error && st == ldst_pkg::ST_IDLE) ##1 !mem_req)
      else $error("out of range offset not refused");
   a_first_access: assert property (s_take_ok |-> s_first_req)
      else $error("first access address wrong");
   a_step_spacing: assert property ((st == ldst_pkg::ST_READ && seen_access) |=>
      mem_addr == (decr_q ? $past(prev_addr) - ldst_pkg::WORD_BYTES
      : $past(prev_addr) + ldst_pkg::WORD_BYTES))
      else $error("access addresses not four bytes apart");
   a_writeback_final: assert property ((st == ldst_pkg::ST_DONE && wb_q) |=>
      (rf_wr_en && rf_wr_addr == base_reg_q && rf_wr_data == mem_addr))
      else $error("writeback value wrong");
   a_dual_second_word: assert property ((rf_wr_en && dual_second_q
      && $past(dual_second_q) && op_q == ldst_pkg::OP_LOAD_DUAL_WORDS)
      |-> (rf_wr_addr == second_q && mem_addr == start_q + ldst_pkg::WORD_BYTES))
      else $error("second dual word misplaced");
endmodule

// File: verif/mem_model.sv
// Memory system model that answers the unit's data bus.
`timescale 1ns/1ps
module mem_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [1:0] wait_cnt;
   // ---------------------------------------------------------------
   // Answer after zero or three idle cycles; data toggles when idle.
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (sys_rst) begin
         wait_cnt <= 2'h0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_req && !mem_ack) begin
         if (!slow || wait_cnt == 2'h3) begin
            mem_ack <= 1'b1;
            mem_rdata <= {mem_addr[15:0], ~mem_addr[15:0]};
            wait_cnt <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the load and store execution unit.
`timescale 1ns/1ps
module testbench;
   logic ref_clk, sys_rst, cmd_valid, cmd_ready, cmd_writeback, cmd_by_label;
   ldst_pkg::op_t cmd_op;
   ldst_pkg::size_t cmd_size;
   ldst_pkg::mode_t cmd_mode;
   logic [31:0] cmd_operand, cmd_pc, cmd_base_val, rf_rd_data, rf_wr_data, branch_addr;
   logic [31:0] mem_addr, mem_wdata, mem_rdata;
   logic [3:0] cmd_target_reg, cmd_second_target_reg, cmd_base_reg, rf_rd_addr, rf_wr_addr;
   logic [15:0] cmd_reg_list;
   logic [1:0] mem_size;
   logic cmd_error, done, rf_wr_en, flags_wr_en, branch_valid, branch_fault;
   logic mem_req, mem_we, mem_ack, slow, got_err;
   logic [35:0] wq[$];
   logic [31:0] aq[$], sq[$];
   logic [1:0] zq[$];
   logic [32:0] bq[$];
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int flag_hits = 0;
   // ---------------------------------------------------------------
   // Design, memory and register file
   // ---------------------------------------------------------------
   assign rf_rd_data = {16'hc0de, 12'h000, rf_rd_addr};
   ldst_exec uut (.ref_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_size, .cmd_mode,
      .cmd_writeback, .cmd_by_label, .cmd_operand, .cmd_pc, .cmd_target_reg,
      .cmd_second_target_reg, .cmd_base_reg, .cmd_base_val, .cmd_reg_list, .cmd_error,
      .done, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .flags_wr_en,
      .branch_valid, .branch_addr, .branch_fault, .mem_req, .mem_we, .mem_addr, .mem_size,
      .mem_wdata, .mem_ack, .mem_rdata);
   mem_model mem (.ref_clk, .sys_rst, .slow, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (rf_wr_en) wq.push_back({rf_wr_addr, rf_wr_data});
      if (mem_req && mem_ack) begin
         aq.push_back(mem_addr);
         zq.push_back(mem_size);
         if (mem_we) sq.push_back(mem_wdata);
      end
      if (branch_valid) bq.push_back({branch_fault, branch_addr});
      if (!sys_rst && flags_wr_en !== 1'b0) flag_hits++;
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic run_cmd();
      int n;
      wq = {};
      aq = {};
      sq = {};
      zq = {};
      bq = {};
      while (cmd_ready !== 1'b1) @(negedge ref_clk);
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && cmd_error !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      got_err = cmd_error;
      if (n == 100) err_count++;
      @(negedge ref_clk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_single();
      logic [31:0] e [5];
      e = '{32'h1f04_e0fb, 32'h0000_00fb, 32'hffff_fffb, 32'h0000_e0fb, 32'hffff_e0fb};
      cmd_op = ldst_pkg::OP_LOAD_REGISTER;
      cmd_pc = 32'h0000_1002;
      cmd_operand = 32'h0000_0f00;
      for (int i = 0; i < 5; i++) begin
         cmd_size = ldst_pkg::size_t'(i);
         cmd_target_reg = 4'(i + 1);
         run_cmd();
         check({4'h0, aq[0]}, 36'h0_0000_1f04);
         check({34'h0, zq[0]}, 36'(i == 0 ? 2 : (i - 1) / 2));
         check(wq[0], {cmd_target_reg, e[i]});
      end
      cmd_size = ldst_pkg::SIZE_WORD;
   endtask
   task automatic t_range();
      logic [31:0] o [6];
      o = '{32'h0fff, 32'h1000, 32'h1005, 32'h1004, 32'h03fc, 32'hffff_fc03};
      cmd_pc = 32'h0000_2000;
      for (int i = 0; i < 6; i++) begin
         cmd_op = ldst_pkg::op_t'(i / 4);
         cmd_by_label = (i / 2 == 1);
         cmd_operand = o[i];
         run_cmd();
         check({35'h0, got_err}, 36'(i % 2));
         check(36'(aq.size()), 36'(i % 2 ? 0 : i / 4 + 1));
         if (i == 2) check({4'h0, aq[0]}, 36'h0_0000_1005);
      end
      cmd_by_label = 1'b0;
   endtask
   task automatic t_dual();
      cmd_op = ldst_pkg::OP_LOAD_DUAL_WORDS;
      cmd_target_reg = 4'h2;
      cmd_pc = 32'h0000_0100;
      cmd_operand = 32'h0000_0200;
      run_cmd();
      check(wq[0], {4'h2, pat(32'h0304)});
      check(wq[1], {4'h3, pat(32'h0308)});
   endtask
   task automatic t_pc();
      logic [31:0] d;
      // Every command is unconditional, so no if-then placement applies.
      cmd_op = ldst_pkg::OP_LOAD_REGISTER;
      cmd_target_reg = 4'hf;
      for (int i = 0; i < 2; i++) begin
         cmd_operand = 32'(16 + i);
         d = pat(32'(32'h0114 + i));
         run_cmd();
         check({3'h0, bq[0]}, {3'h0, ~d[0], d & 32'hffff_fffe});
         check(36'(wq.size()), 36'h0);
      end
   endtask
   task automatic t_multi();
      logic [31:0] a;
      logic [3:0] r [3];
      logic [3:0] rg;
      logic dn;
      int nw;
      r = '{4'h0, 4'h2, 4'h7};
      cmd_base_reg = 4'h4;
      cmd_base_val = 32'h0000_3000;
      // The list is non-empty and holds no SP, PC or base.
      cmd_reg_list = 16'h0085;
      for (int m = 0; m < 14; m++) begin
         cmd_op = ldst_pkg::op_t'(2 + m / 7);
         cmd_mode = ldst_pkg::mode_t'(m % 7);
         cmd_writeback = 1'(m % 2);
         slow = 1'(m / 2 % 2);
         dn = (m % 7) inside {2, 4, 6};
         nw = m < 7 ? 3 : 0;
         run_cmd();
         check(36'(aq.size()), 36'h3);
         for (int k = 0; k < 3; k++) begin
            a = dn ? 32'h3000 - 4 * k : 32'h3000 + 4 * k;
            rg = dn ? r[2 - k] : r[k];
            check({4'h0, aq[k]}, {4'h0, a});
            check({34'h0, zq[k]}, 36'h2);
            if (m < 7) check(wq[k], {rg, pat(a)});
            else check({4'h0, sq[k]}, {20'h0c0de, 12'h000, rg});
         end
         check(36'(wq.size()), 36'(nw + m % 2));
         if (m % 2) check(wq[nw], {4'h4, dn ? 32'h2ff8 : 32'h3008});
      end
   endtask
   // ---------------------------------------------------------------
   // Clock and main sequence
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = ldst_pkg::OP_LOAD_REGISTER;
      cmd_size = ldst_pkg::SIZE_WORD;
      cmd_mode = ldst_pkg::MODE_DEFAULT;
      cmd_writeback = 1'b0;
      cmd_by_label = 1'b0;
      cmd_operand = 32'h0000_0000;
      cmd_pc = 32'h0000_0000;
      cmd_target_reg = 4'h2;
      cmd_second_target_reg = 4'h3;
      cmd_base_reg = 4'h4;
      cmd_base_val = 32'h0000_0000;
      cmd_reg_list = 16'h0001;
      slow = 1'b0;
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_single();
      t_range();
      t_dual();
      t_pc();
      t_multi();
      check(36'(flag_hits), 36'h0);
      give_verdict();
   end
endmodule
